// ### rtl/rhs_map.svh
// Constants of the radio host serial slave: command fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RHS_MAP_SVH
`define RHS_MAP_SVH

// ----------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------
`define RHS_CMD_REG_BIT   7
`define RHS_CMD_WR_BIT    6
`define RHS_CMD_FB_BIT    5
`define RHS_REG_ADDR_MSB  5
`define RHS_BYTE_MSB      7

// ----------------------------------------------------------------------
// Reset values and idle fill byte
// ----------------------------------------------------------------------
`define RHS_STATUS_RST    8'h00
`define RHS_ADDR_RST      8'h00
`define RHS_IDLE_FILL     8'h00

// ----------------------------------------------------------------------
// Timing: system clock in kHz, fastest asynchronous serial clock in kHz
// ----------------------------------------------------------------------
`define RHS_CLK_KHZ       100000
`define RHS_SCLK_MAX_KHZ  7500
`define RHS_SCLK_HALF_CYC (`RHS_CLK_KHZ / (2 * `RHS_SCLK_MAX_KHZ))
`define RHS_CLKOUT_HALF   8

`endif

// ### rtl/rhs_pkg.sv
// Types shared by the radio host serial slave modules.
// Assumes rhs_map.svh sits on the include path.
`include "rhs_map.svh"

package rhs_pkg;

   // ----------------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------------

   // Serial transaction phase; Gray along idle, command, address, data.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CMD  = 2'h1,
      ST_ADDR = 2'h3,
      ST_DATA = 2'h2
   } rhs_st_e;

   // Access target decoded from the command byte.
   typedef enum logic [1:0] {
      MD_REG  = 2'h0,
      MD_FB   = 2'h1,
      MD_SRAM = 2'h2
   } rhs_mode_e;

   // Transceiver state reported by the core to the side-band logic.
   typedef enum logic [2:0] {
      TS_OFF       = 3'h0,
      TS_PREP_DEEP = 3'h1,
      TS_DEEP      = 3'h2,
      TS_SLEEP     = 3'h3,
      TS_OTHER     = 3'h5,
      TS_TX_RDY    = 3'h6,
      TS_ARET_RDY  = 3'h7
   } rhs_trx_e;

   // ----------------------------------------------------------------------
   // State records
   // ----------------------------------------------------------------------
   typedef struct packed {
      rhs_st_e     state;
      rhs_mode_e   mode;
      logic        wr;
      logic        done;
      logic        inc;
      logic        sclk_d;
      logic [2:0]  bit_cnt;
      logic [7:0]  rx_sh;
      logic [7:0]  tx_sh;
      logic [7:0]  addr;
      logic [7:0]  wr_data;
      logic        rd_stb;
      logic        wr_stb;
      logic        cipher;
      logic        busy;
   } rhs_spi_s;

   typedef struct packed {
      logic        trig_d;
      logic        irq;
      logic        wake;
      logic        sleep;
      logic        deep;
      logic        txs;
      logic        ts;
      logic        clko;
      logic [7:0]  div;
   } rhs_side_s;

endpackage

// ### rtl/rhs_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/100ps
`default_nettype none

module rhs_sync #(
   parameter int unsigned     W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
) (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   // Stage one is read only by stage two, never by other logic.
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } rhs_sync_s;

   rhs_sync_s s_reg;    // Present stages.
   rhs_sync_s s_next;   // Next stages.

   // Shift the pins through both stages.
   always_comb begin
      s_next.meta = d;
      s_next.stab = s_reg.meta;
   end

   // Reset to the idle level so nothing sees a false edge.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= {RST_VAL, RST_VAL};
      end else begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.stab;

endmodule

`default_nettype wire

// ### rtl/rhs_side.sv
// Side-band pins: interrupt, sleep/transmit trigger, time stamp, clock out.
// Assumes the trigger input is already synchronised to clk.
`timescale 1ns/100ps
`default_nettype none
`include "rhs_map.svh"

module rhs_side
   import rhs_pkg::*;
#(
   parameter logic [7:0]    CLKOUT_HALF = 8'(`RHS_CLKOUT_HALF)
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        trig_s,
   input  wire logic [2:0]  trx_state,
   input  wire logic        irq_event,
   input  wire logic        fb_empty,
   input  wire logic        fb_empty_irq_en,
   input  wire logic        rx_start,
   input  wire logic        tx_frame,
   input  wire logic        auto_retry_tx_mode,
   input  wire logic        ts_enable,
   input  wire logic        clock_output_en,
   output logic             irq,
   output logic             wake_req,
   output logic             sleep_req,
   output logic             deepest_low_power_state_req,
   output logic             tx_start,
   output logic             timestamp_output,
   output logic             clock_output
);

   rhs_side_s s_reg;    // Present side-band state.
   rhs_side_s s_next;   // Next side-band state.

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic rise;
      logic fall;
      rise = trig_s & ~s_reg.trig_d;
      fall = ~trig_s & s_reg.trig_d;
      s_next = s_reg;
      s_next.trig_d = trig_s;
      s_next.irq = irq_event | (fb_empty_irq_en & fb_empty);
      s_next.txs = rise & ((trx_state == TS_TX_RDY) ||
                           (trx_state == TS_ARET_RDY));
      s_next.sleep = rise & (trx_state == TS_OFF);
      s_next.deep = rise & (trx_state == TS_PREP_DEEP);
      s_next.wake = fall & ((trx_state == TS_SLEEP) ||
                            (trx_state == TS_DEEP));
      s_next.ts = ts_enable & (auto_retry_tx_mode ? tx_frame : rx_start);
      // The clock output may be off; the serial slave never relies on it.
      if (!clock_output_en) begin
         s_next.clko = 1'b0;
         s_next.div = 8'h00;
      end else if (s_reg.div >= CLKOUT_HALF - 8'h01) begin
         s_next.clko = ~s_reg.clko;
         s_next.div = 8'h00;
      end else begin
         s_next.div = s_reg.div + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign irq              = s_reg.irq;
   assign wake_req         = s_reg.wake;
   assign sleep_req        = s_reg.sleep;
   assign deepest_low_power_state_req   = s_reg.deep;
   assign tx_start         = s_reg.txs;
   assign timestamp_output = s_reg.ts;
   assign clock_output     = s_reg.clko;

endmodule

`default_nettype wire

// ### rtl/rhs_spi_slave.sv
// Host serial slave of the radio: command decode and byte streaming toward
// registers, frame buffer, SRAM and cipher, plus the side-band pins.
// Assumes the serial pins are asynchronous to clk, the master clocks in
// mode 0 no faster than a quarter of clk, and the core answers a read
// strobe with rd_data valid within two clk cycles.
`timescale 1ns/100ps
`default_nettype none
`include "rhs_map.svh"

// Operation
// - Select low frames one transaction.
// - Eight clocks move one byte each way.
// - Most significant bit first both ways.
// - Output driven only while selected.
// - Driver also on in reset with select.
// - Input sampled on rising clock edge.
// - Output advances on falling clock edge.
// - Works with the clock output off.
// - Register two bytes, frame buffer two or more, SRAM three or more.
// - First byte is the command byte.
// - Decode register, frame buffer, SRAM, direction.
// - One protocol reaches all four targets.
// - Interrupt output doubles as empty flag.
// - Trigger acts by transceiver state.
// - Active low reset input resets all.
// - Time stamp for receive or retry send.
// - First returned byte is status prefix.
// - Register read returns data second.
// - Buffer address advances per data byte.
module rhs_spi_slave
   import rhs_pkg::*;
#(
   parameter logic [7:0]    CIPHER_LO = 8'h80,  // Cipher window, low end.
   parameter logic [7:0]    CIPHER_HI = 8'h9f   // Cipher window, high end.
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        spi_sclk,
   input  wire logic        spi_sel_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   output logic             spi_miso_oe_n,
   input  wire logic [7:0]  status_prefix_byte,
   output logic [1:0]       acc_mode,
   output logic             acc_write,
   output logic [7:0]       acc_addr,
   output logic             acc_cipher,
   output logic             rd_stb,
   input  wire logic [7:0]  rd_data,
   output logic             wr_stb,
   output logic [7:0]       wr_data,
   output logic             busy,
   input  wire logic        sleep_tx_trigger,
   input  wire logic [2:0]  trx_state,
   input  wire logic        irq_event,
   input  wire logic        fb_empty,
   input  wire logic        fb_empty_irq_en,
   input  wire logic        rx_start,
   input  wire logic        tx_frame,
   input  wire logic        auto_retry_tx_mode,
   input  wire logic        ts_enable,
   input  wire logic        clock_output_en,
   output logic             irq,
   output logic             wake_req,
   output logic             sleep_req,
   output logic             deepest_low_power_state_req,
   output logic             tx_start,
   output logic             timestamp_output,
   output logic             clock_output
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------

   logic [3:0]  pins_s;     // Synchronised trigger, mosi, select, clock.
   logic        sclk_s;     // Serial clock level in the clk domain.
   logic        sel_n_s;    // Select level in the clk domain.
   logic        mosi_s;     // Serial data in the clk domain.
   logic        trig_s;     // Sleep/transmit trigger in the clk domain.

   // Select resets high so a reset never looks like a frame start.
   // Sampled clock edges.
   rhs_sync #(
      .W       (4),
      .RST_VAL (4'h2)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({sleep_tx_trigger, spi_mosi, spi_sel_n, spi_sclk}),
      .q    (pins_s)
   );

   assign sclk_s  = pins_s[0];
   assign sel_n_s = pins_s[1];
   assign mosi_s  = pins_s[2];
   assign trig_s  = pins_s[3];

   // ----------------------------------------------------------------------
   // Serial engine state
   // ----------------------------------------------------------------------

   rhs_spi_s s_reg;    // Present engine state.
   rhs_spi_s s_next;   // Next engine state.

   // The whole transaction walks through one combinational next-state
   // process; every strobe it raises lives for a single clk cycle.
   always_comb begin
      logic        rise;   // Rising serial clock seen this cycle.
      logic        fall;   // Falling serial clock seen this cycle.
      logic [7:0]  b;      // Byte completed by this rising edge.
      rhs_st_e     cur;    // Phase, with idle promoted to command.
      rise = sclk_s & ~s_reg.sclk_d;
      fall = ~sclk_s & s_reg.sclk_d;
      b = {s_reg.rx_sh[6:0], mosi_s};
      cur = (s_reg.state == ST_IDLE) ? ST_CMD : s_reg.state;
      s_next = s_reg;
      s_next.sclk_d = sclk_s;
      s_next.rd_stb = 1'b0;
      s_next.wr_stb = 1'b0;

      // A pending write increment lands one cycle after its strobe, so
      // the address shown with the strobe is the one being written.
      if (s_reg.inc) begin
         s_next.addr = s_reg.addr + 8'h01;
         s_next.inc = 1'b0;
      end

      if (sel_n_s) begin
         s_next.state = ST_IDLE;
         s_next.bit_cnt = 3'h0;
         s_next.done = 1'b0;
         s_next.busy = 1'b0;
         s_next.tx_sh = status_prefix_byte;
      end else begin
         s_next.busy = 1'b1;
         s_next.state = cur;
         if (rise) begin
            s_next.rx_sh = b;
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            if (s_reg.bit_cnt == 3'h7) begin
               case (cur)
                  ST_CMD: begin
                     s_next.wr = b[`RHS_CMD_WR_BIT];
                     s_next.done = 1'b0;
                     if (b[`RHS_CMD_REG_BIT]) begin
                        s_next.mode = MD_REG;
                        s_next.addr = {2'b00, b[`RHS_REG_ADDR_MSB:0]};
                        s_next.rd_stb = ~b[`RHS_CMD_WR_BIT];
                        s_next.state = ST_DATA;
                     end else if (b[`RHS_CMD_FB_BIT]) begin
                        // Frame buffer always restarts at its first byte.
                        s_next.mode = MD_FB;
                        s_next.addr = `RHS_ADDR_RST;
                        s_next.rd_stb = ~b[`RHS_CMD_WR_BIT];
                        s_next.state = ST_DATA;
                     end else begin
                        // SRAM and cipher take an address byte next.
                        s_next.mode = MD_SRAM;
                        s_next.state = ST_ADDR;
                     end
                  end
                  ST_ADDR: begin
                     s_next.addr = b;
                     s_next.rd_stb = ~s_reg.wr;
                     s_next.state = ST_DATA;
                  end
                  ST_DATA: begin
                     if (s_reg.mode == MD_REG) begin
                        if (s_reg.wr && !s_reg.done) begin
                           s_next.wr_stb = 1'b1;
                           s_next.wr_data = b;
                        end
                        s_next.done = 1'b1;
                     end else if (s_reg.wr) begin
                        s_next.wr_stb = 1'b1;
                        s_next.wr_data = b;
                        s_next.inc = 1'b1;
                     end else begin
                        s_next.addr = s_reg.addr + 8'h01;
                        s_next.rd_stb = 1'b1;
                     end
                  end
                  default: begin
                     s_next.state = ST_IDLE;
                  end
               endcase
            end
         end else if (fall) begin
            if (s_reg.bit_cnt == 3'h0) begin
               if ((s_reg.state == ST_DATA) && !s_reg.wr && !s_reg.done) begin
                  s_next.tx_sh = rd_data;
               end else begin
                  s_next.tx_sh = `RHS_IDLE_FILL;
               end
            end else begin
               s_next.tx_sh = {s_reg.tx_sh[6:0], 1'b0};
            end
         end
      end

      s_next.cipher = (s_next.mode == MD_SRAM) &&
                      (s_next.addr >= CIPHER_LO) &&
                      (s_next.addr <= CIPHER_HI);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg.state   <= ST_IDLE;
         s_reg.mode    <= MD_REG;
         s_reg.wr      <= 1'b0;
         s_reg.done    <= 1'b0;
         s_reg.inc     <= 1'b0;
         s_reg.sclk_d  <= 1'b0;
         s_reg.bit_cnt <= 3'h0;
         s_reg.rx_sh   <= 8'h00;
         s_reg.tx_sh   <= `RHS_STATUS_RST;
         s_reg.addr    <= `RHS_ADDR_RST;
         s_reg.wr_data <= 8'h00;
         s_reg.rd_stb  <= 1'b0;
         s_reg.wr_stb  <= 1'b0;
         s_reg.cipher  <= 1'b0;
         s_reg.busy    <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------------
   // Output driver
   // ----------------------------------------------------------------------

   // The shift register is preloaded while deselected, so the first bit
   // is present the moment the driver opens, with only pad delay.
   assign spi_miso = s_reg.tx_sh[`RHS_BYTE_MSB];

   // Also enabled during reset.
   // The enable bypasses the flops on purpose: a register would be held
   // off by the reset and would lag the select by the synchroniser.
   assign spi_miso_oe_n = spi_sel_n;

   // ----------------------------------------------------------------------
   // Core access port
   // ----------------------------------------------------------------------
   assign acc_mode   = s_reg.mode;
   assign acc_write  = s_reg.wr;
   assign acc_addr   = s_reg.addr;
   assign acc_cipher = s_reg.cipher;
   assign rd_stb     = s_reg.rd_stb;
   assign wr_stb     = s_reg.wr_stb;
   assign wr_data    = s_reg.wr_data;
   assign busy       = s_reg.busy;

   // ----------------------------------------------------------------------
   // Side-band pins
   // ----------------------------------------------------------------------

   rhs_side #(
      .CLKOUT_HALF (8'(`RHS_CLKOUT_HALF))
   ) u_side (
      .clk                (clk),
      .nrst               (nrst),
      .trig_s             (trig_s),
      .trx_state          (trx_state),
      .irq_event          (irq_event),
      .fb_empty           (fb_empty),
      .fb_empty_irq_en    (fb_empty_irq_en),
      .rx_start           (rx_start),
      .tx_frame           (tx_frame),
      .auto_retry_tx_mode (auto_retry_tx_mode),
      .ts_enable          (ts_enable),
      .clock_output_en    (clock_output_en),
      .irq                (irq),
      .wake_req           (wake_req),
      .sleep_req          (sleep_req),
      .deepest_low_power_state_req     (deepest_low_power_state_req),
      .tx_start           (tx_start),
      .timestamp_output   (timestamp_output),
      .clock_output       (clock_output)
   );

endmodule

`default_nettype wire

// ### verification/rhs_spi_slave_sva.sv
// Concurrent checks on the ports of the radio host serial slave.
// Assumes clk is the only domain and nrst its asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module rhs_spi_slave_sva
   import rhs_pkg::*;
(
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       spi_sel_n,
   input wire logic       spi_miso_oe_n,
   input wire logic [1:0] acc_mode,
   input wire logic [7:0] acc_addr,
   input wire logic       rd_stb,
   input wire logic       wr_stb,
   input wire logic       irq_event,
   input wire logic       fb_empty,
   input wire logic       fb_empty_irq_en,
   input wire logic       irq,
   input wire logic       rx_start,
   input wire logic       tx_frame,
   input wire logic       auto_retry_tx_mode,
   input wire logic       ts_enable,
   input wire logic       timestamp_output,
   input wire logic       clock_output_en,
   input wire logic       clock_output,
   input wire logic       sleep_req,
   input wire logic       tx_start
);
   // ----------------------------------------------------------------------
   // Helper terms
   // ----------------------------------------------------------------------
   logic irq_src;  // Level the interrupt pin should follow.
   logic ts_src;   // Level the time stamp pin should follow.
   assign irq_src = irq_event | (fb_empty_irq_en & fb_empty);
   assign ts_src  = ts_enable & (auto_retry_tx_mode ? tx_frame : rx_start);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // A buffer write must be followed by the address step one cycle later.
   sequence s_buf_wr;
      wr_stb && acc_mode != 2'h0;
   endsequence
   sequence s_off_twice;
      !clock_output_en ##1 !clock_output_en;
   endsequence

   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   // The driver must follow select even while reset is held.
   AST_OE_SEL: assert property (disable iff (1'b0)
      spi_miso_oe_n == spi_sel_n) else $error("miso enable not select");
   AST_RD_PULSE: assert property (rd_stb |=> !rd_stb)
      else $error("read strobe longer than one cycle");
   AST_WR_PULSE: assert property (wr_stb |=> !wr_stb)
      else $error("write strobe longer than one cycle");
   AST_STB_EXCL: assert property (!(rd_stb && wr_stb))
      else $error("read and write strobe together");
   AST_ADDR_INC: assert property (s_buf_wr |=>
      acc_addr == $past(acc_addr) + 8'h01) else $error("no address step");
   AST_REG_ADDR: assert property ((rd_stb || wr_stb) &&
      acc_mode == 2'h0 |-> acc_addr[7:6] == 2'b00)
      else $error("register address above six bits");
   AST_IRQ: assert property ($past(nrst) |-> irq == $past(irq_src))
      else $error("interrupt does not follow its sources");
   AST_TS: assert property ($past(nrst) |->
      timestamp_output == $past(ts_src)) else $error("time stamp wrong");
   AST_CLKO_OFF: assert property (s_off_twice |-> !clock_output)
      else $error("clock output runs while disabled");
   AST_TRIG_PULSE: assert property (sleep_req || tx_start |=>
      !sleep_req && !tx_start) else $error("trigger pulse too long");
endmodule

bind rhs_spi_slave rhs_spi_slave_sva rhs_spi_slave_sva_i (.clk, .nrst,
   .spi_sel_n, .spi_miso_oe_n, .acc_mode, .acc_addr, .rd_stb, .wr_stb,
   .irq_event, .fb_empty, .fb_empty_irq_en, .irq, .rx_start, .tx_frame,
   .auto_retry_tx_mode, .ts_enable, .timestamp_output, .clock_output_en,
   .clock_output, .sleep_req, .tx_start);
`default_nettype wire

// ### verification/rhs_host_model.sv
// Mode 0 serial master standing in for the host microcontroller.
// Assumes the caller waits for settling; the model owns the miso pull-up.
`timescale 1ns/100ps
`default_nettype none

module rhs_host_model (
   output logic      sclk,
   output logic      sel_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe_n
);
   logic       line;  // Resolved miso level seen by the master.
   logic [7:0] rx;    // Last whole byte taken in.
   event       done;  // Fires once a whole byte has been taken.

   assign line = miso_oe_n ? 1'b1 : miso;

   // Idle: clock low and still, select released.
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      mosi = 1'b1;
   end

   // select frames transaction; the wait covers sync and idle gap.
   task automatic sel(input logic v);
      sel_n = v;
      #200;
   endtask

   // MSB first, sample rise, shift fall
   task automatic xfer(input logic [7:0] tx, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         mosi = tx[i];
         #62.5 sclk = 1'b1;
         rx[i] = line;
         #62.5 sclk = 1'b0;
      end
      // Hold time is over, so the line must not keep the last bit.
      mosi = ~mosi;
      if (n == 8) ->done;
   endtask
endmodule
`default_nettype wire

// ### verification/radio_host_spi_slave_tb.sv
// Self-checking bench of the radio host serial slave with a master model.
// Assumes rhs_host_model and the bound checker are compiled beforehand.
`timescale 1ns/100ps
`default_nettype none

module radio_host_spi_slave_tb;
   import rhs_pkg::*;
   localparam logic [7:0] CLO = 8'h80;  // Cipher window, low end.
   localparam logic [7:0] CHI = 8'h9f;  // Cipher window, high end.
   logic        clk = 1'b0, nrst = 1'b0, sclk, sel_n, mosi, miso, oe_n;
   logic [7:0]  status, addr, wr_data, rd_data, st, d, ba;
   logic [1:0]  mode;
   logic [2:0]  trx;
   logic [5:0]  a;
   logic        wr, cipher, rd_stb, wr_stb, busy, trig = 1'b0, ckoen = 1'b0;
   logic [6:0]  side = 7'h0;  // Random same-clock side-band inputs.
   logic        irq, wake, slp, deep, txs, ts, cko;
   logic [8:0]  exp_rx[$];    // Care bit and expected miso byte.
   logic [16:0] exp_wr[$];    // Cipher flag, address and write data.
   int          n_mismatch = 0, checked = 0, cyc = 0;

   always #5 clk = ~clk;

   rhs_spi_slave #(.CIPHER_LO(CLO), .CIPHER_HI(CHI)) rhs_spi_slave_i (
      .clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_sel_n(sel_n),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(oe_n),
      .status_prefix_byte(status), .acc_mode(mode), .acc_write(wr),
      .acc_addr(addr), .acc_cipher(cipher), .rd_stb(rd_stb),
      .rd_data(rd_data), .wr_stb(wr_stb), .wr_data(wr_data), .busy(busy),
      .sleep_tx_trigger(trig), .trx_state(trx), .irq_event(side[0]),
      .fb_empty(side[1]), .fb_empty_irq_en(side[2]), .rx_start(side[3]),
      .tx_frame(side[4]), .auto_retry_tx_mode(side[5]),
      .ts_enable(side[6]), .clock_output_en(ckoen), .irq(irq),
      .wake_req(wake), .sleep_req(slp), .deepest_low_power_state_req(deep),
      .tx_start(txs), .timestamp_output(ts), .clock_output(cko));
   rhs_host_model rhs_host_model_i (.sclk(sclk), .sel_n(sel_n),
      .mosi(mosi), .miso(miso), .miso_oe_n(oe_n));

   // ----------------------------------------------------------------------
   // Core stand-in, side-band stimulus, checking
   // ----------------------------------------------------------------------
   // Storage content is a fixed mapping of the address.
   function automatic logic [7:0] f(input logic [7:0] ad);
      return ad ^ 8'ha5;
   endfunction

   // Read answers arrive half a cycle after the strobe, within the allowance.
   always @(negedge clk) begin
      if (rd_stb === 1'b1) rd_data <= f(addr);
      side <= 7'($urandom);
      trx <= 3'($urandom);
      if ($urandom % 40 == 0) trig <= ~trig;
      if ($urandom % 90 == 0) ckoen <= ~ckoen;
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Each finished byte on miso is matched with the oldest note.
   always @(rhs_host_model_i.done) begin
      if (exp_rx.size() == 0) check(17'h1, 17'h0);
      else if (exp_rx[0][8]) check(17'(rhs_host_model_i.rx), 17'(exp_rx[0][7:0]));
      if (exp_rx.size() > 0) void'(exp_rx.pop_front());
   end

   // Each write strobe is matched with the oldest expected write.
   always @(negedge clk) begin
      if (wr_stb === 1'b1) begin
         if (exp_wr.size() == 0) check(17'h1, 17'h0);
         else check({cipher, addr, wr_data}, exp_wr.pop_front());
      end
   end

   task automatic open;
      @(negedge clk);
      st = 8'($urandom);
      status = st;
      rhs_host_model_i.sel(1'b0);
   endtask

   task automatic go(input logic [7:0] tx, input logic [8:0] ex);
      exp_rx.push_back(ex);
      rhs_host_model_i.xfer(tx, 8);
   endtask

   task automatic results;
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // A hung handshake ends the run as a failure.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      void'($urandom(66));
      // select held low while reset is asserted
      repeat (2) @(negedge clk);
      rhs_host_model_i.sel_n = 1'b0;
      repeat (10) @(negedge clk);
      rhs_host_model_i.sel_n = 1'b1;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      #200;
      // a partial byte is dropped at deselect
      open();
      rhs_host_model_i.xfer(8'hc5, 4);
      rhs_host_model_i.sel(1'b1);
      // register read, then write with a surplus byte
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
         d = 8'($urandom);
         open();
         go({2'b10, a}, {1'b1, st});
         go(d, {1'b1, f({2'b00, a})});
         rhs_host_model_i.sel(1'b1);
         open();
         go({2'b11, a}, {1'b1, st});
         exp_wr.push_back({1'b0, 2'b00, a, d});
         go(d, 9'h0);
         go(~d, 9'h100);
         rhs_host_model_i.sel(1'b1);
      end
      // buffer writes then reads, reserved bits random
      for (int m = 0; m < 4; m++) begin
         open();
         go({1'b0, m < 2, m % 2 == 0, 5'($urandom)}, {1'b1, st});
         if (m % 2 == 1) go(CHI, {m == 3, 8'h00});
         for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            ba = (m % 2 == 1) ? CHI + 8'(i) : 8'(i);
            if (m < 2)
               exp_wr.push_back({m == 1 && ba >= CLO && ba <= CHI, ba, d});
            go(d, (m < 2) ? 9'h0 : {1'b1, f(ba)});
         end
         rhs_host_model_i.sel(1'b1);
      end
      repeat (50) @(negedge clk);
      check(17'(exp_rx.size() + exp_wr.size()), 17'h0);
      results();
   end
endmodule
`default_nettype wire
